// file: rtl/genset_protection_monitor.sv
// Genset protection monitor with APB register access
`timescale 1ns/1ps
`include "gpm_defs.svh"
module genset_protection_monitor
  import gpm_pkg::*;
#(
  parameter int TICK_CYCLES = `GPM_TICK_CYCLES,
  parameter int NT = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic feedingLoad,
  input wire logic [15:0] genFreq,
  input wire logic [15:0] battV,
  input wire logic [2:0][15:0] phaseV,
  input wire logic [2:0][15:0] phaseI,
  input wire logic signed [31:0] actPower,
  output logic warnOut,
  output logic dumpOut,
  output logic shutOut,
  output logic engineStop
);

  // ----------------------------------------
  // Configuration and status storage
  // ----------------------------------------
  logic [1:0] nomSel; // 0 primary, 1 secondary, 2 tertiary
  action_t vUnbAct; // Voltage unbalance response
  action_t iUnbAct; // Current unbalance response
  logic ocAct; // Overcurrent response
  logic [15:0] nomFreq; // Nominal frequency in Hz
  logic [7:0] pctLowShut; // Signed percent offsets
  logic [7:0] pctHighWarn;
  logic [7:0] pctHighShut;
  logic [15:0] batLowWarn; // Battery limits in 0.1 V
  logic [15:0] batLowShut;
  logic [15:0] batHighWarn;
  logic [15:0] batHighShut;
  logic [7:0] vUnbLim; // Unbalance limits in percent
  logic [7:0] iUnbLim;
  logic [15:0] revWarnLim; // Reverse power limits in kW
  logic [15:0] revDumpLim;
  logic [15:0] ocLim1; // Overcurrent limits in A
  logic [15:0] ocLim2;
  logic [15:0] ocLim3;
  logic [15:0] ovlLim; // Overload limit in kW
  logic [15:0] frqTime; // Fail timers in ticks
  logic [15:0] batTime;
  logic [15:0] revTime;
  logic [15:0] ovlTime;
  logic [6:0] ocMult; // Overcurrent time multiplier
  logic [12:0] status; // Sticky fault causes

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Scaled frequency threshold: nominal * 10 * (100 + pct)
  function automatic logic [31:0] freqLimit(input logic [15:0] nom, input logic [7:0] pct);
    logic [9:0] f;
    f = {{2{pct[7]}}, pct} + 10'h064;
    if (f[9]) begin
      f = 10'h000;
    end
    return 32'(nom) * 32'(f) * 32'h0000000A;
  endfunction

  // Any phase farther from the average than lim percent; zero disables
  function automatic logic unbal(input logic [2:0][15:0] ph, input logic [7:0] lim);
    logic [17:0] sum;
    logic [17:0] t;
    logic [17:0] d;
    logic [31:0] rhs;
    logic flag;
    sum = 18'(ph[0]) + 18'(ph[1]) + 18'(ph[2]);
    rhs = 32'(lim) * 32'(sum);
    flag = 1'b0;
    for (int k = 0; k < 3; k++) begin
      t = 18'(ph[k]) * 18'h00003;
      d = (t > sum) ? (t - sum) : (sum - t);
      if ((32'(d) * 32'h00000064) > rhs) begin
        flag = 1'b1;
      end
    end
    return (lim != 8'h00) && flag;
  endfunction

  // Map an unbalance fault onto an alarm class by action code
  function automatic alarm_t actClass(input action_t act, input logic flt);
    alarm_t a;
    a.shut = flt && (act == ACT_SHUT);
    a.dump = flt && (act == ACT_DUMP);
    a.warn = flt && (act == ACT_WARN);
    return a;
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic setupPh; // Setup phase of any transfer
  logic wrEn; // Write takes effect
  logic mapped; // Address hits a register
  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pwrite && pready;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `GPM_LIVE);

  // Configuration writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nomSel <= 2'h0;
      vUnbAct <= ACT_NONE;
      iUnbAct <= ACT_NONE;
      ocAct <= 1'b0;
      nomFreq <= `GPM_NOMFREQ_RST;
      pctLowShut <= `GPM_LOWSHUT_RST;
      pctHighWarn <= `GPM_HIGHWARN_RST;
      pctHighShut <= `GPM_HIGHSHUT_RST;
      batLowWarn <= `GPM_BLW_RST;
      batLowShut <= `GPM_BLS_RST;
      batHighWarn <= `GPM_BHW_RST;
      batHighShut <= `GPM_BHS_RST;
      vUnbLim <= 8'h00;
      iUnbLim <= 8'h00;
      revWarnLim <= 16'h0000;
      revDumpLim <= 16'h0000;
      ocLim1 <= 16'h0000;
      ocLim2 <= 16'h0000;
      ocLim3 <= 16'h0000;
      ovlLim <= 16'h0000;
      frqTime <= `GPM_FRQT_RST;
      batTime <= `GPM_BATT_RST;
      revTime <= `GPM_REVT_RST;
      ovlTime <= `GPM_OVLT_RST;
      ocMult <= `GPM_OCMULT_RST;
    end else if (wrEn) begin
      case (paddr)
        `GPM_CTRL: begin
          nomSel <= pwdata[1:0];
          vUnbAct <= action_t'(pwdata[5:4]);
          iUnbAct <= action_t'(pwdata[7:6]);
          ocAct <= pwdata[8];
        end
        `GPM_NOMFREQ: nomFreq <= pwdata[15:0];
        `GPM_FREQLIM: begin
          pctLowShut <= pwdata[7:0];
          pctHighWarn <= pwdata[15:8];
          pctHighShut <= pwdata[23:16];
        end
        `GPM_BATLOW: begin
          batLowWarn <= pwdata[15:0];
          batLowShut <= pwdata[31:16];
        end
        `GPM_BATHIGH: begin
          batHighWarn <= pwdata[15:0];
          batHighShut <= pwdata[31:16];
        end
        `GPM_UNBAL: begin
          vUnbLim <= pwdata[7:0];
          iUnbLim <= pwdata[15:8];
        end
        `GPM_REVP: begin
          revWarnLim <= pwdata[15:0];
          revDumpLim <= pwdata[31:16];
        end
        `GPM_OCLIM1: ocLim1 <= pwdata[15:0];
        `GPM_OCLIM2: ocLim2 <= pwdata[15:0];
        `GPM_OCLIM3: ocLim3 <= pwdata[15:0];
        `GPM_OVL: ovlLim <= pwdata[15:0];
        `GPM_TIMER1: begin
          frqTime <= pwdata[15:0];
          batTime <= pwdata[31:16];
        end
        `GPM_TIMER2: begin
          revTime <= pwdata[15:0];
          ovlTime <= pwdata[31:16];
        end
        // Multiplier held inside its legal range
        `GPM_OCMULT: begin
          if (pwdata[6:0] == 7'h00) begin
            ocMult <= 7'h01;
          end else if (pwdata[6:0] > `GPM_OCMULT_MAX) begin
            ocMult <= `GPM_OCMULT_MAX;
          end else begin
            ocMult <= pwdata[6:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Slow tick divider
  // ----------------------------------------
  logic [31:0] divCnt; // Cycle counter
  logic tick; // One-cycle pulse per tick
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (divCnt >= 32'(TICK_CYCLES - 1)) begin
      divCnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      divCnt <= divCnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Limit comparisons
  // ----------------------------------------
  logic [31:0] freqScaled; // Frequency in 0.1 Hz times 100
  logic frqLowShutC;
  logic frqHighWarnC;
  logic frqHighShutC;
  logic frqC; // Any frequency limit crossed
  assign freqScaled = 32'(genFreq) * 32'h00000064;
  assign frqLowShutC = feedingLoad && (freqScaled < freqLimit(nomFreq, pctLowShut));
  assign frqHighWarnC = feedingLoad && (freqScaled > freqLimit(nomFreq, pctHighWarn));
  assign frqHighShutC = feedingLoad && (freqScaled > freqLimit(nomFreq, pctHighShut));
  assign frqC = frqLowShutC || frqHighWarnC || frqHighShutC;

  logic batLowWarnC;
  logic batLowShutC;
  logic batHighWarnC;
  logic batHighShutC;
  logic batC; // Any battery limit crossed
  assign batLowWarnC = battV < batLowWarn;
  assign batLowShutC = battV < batLowShut;
  assign batHighWarnC = battV > batHighWarn;
  assign batHighShutC = battV > batHighShut;
  assign batC = batLowWarnC || batLowShutC || batHighWarnC || batHighShutC;

  logic vUnbC;
  logic iUnbC;
  assign vUnbC = unbal(phaseV, vUnbLim);
  assign iUnbC = unbal(phaseI, iUnbLim);

  logic [31:0] revMag; // Magnitude of negative power
  logic revWarnC;
  logic revDumpC;
  logic revC;
  assign revMag = 32'(-actPower);
  // A zero warning limit switches all reverse power checks off
  assign revWarnC = (revWarnLim != 16'h0000) && actPower[31] && (revMag > 32'(revWarnLim));
  assign revDumpC = (revWarnLim != 16'h0000) && actPower[31] && (revMag > 32'(revDumpLim));
  assign revC = revWarnC || revDumpC;

  // Limit chosen by nominal voltage selection
  logic [15:0] ocSel;
  always_comb begin
    case (nomSel)
      2'h1: ocSel = ocLim2;
      2'h2: ocSel = ocLim3;
      default: ocSel = ocLim1;
    endcase
  end

  logic ocC;
  logic [15:0] ocDelay; // Fewer ticks for larger multiplier
  assign ocC = feedingLoad && (ocSel != 16'h0000) &&
    ((phaseI[0] > ocSel) || (phaseI[1] > ocSel) || (phaseI[2] > ocSel));
  assign ocDelay = 16'(`GPM_OCDELAY_BASE - ocMult);

  logic ovlC;
  assign ovlC = feedingLoad && (ovlLim != 16'h0000) && !actPower[31] &&
    (actPower > 32'(ovlLim));

  // ----------------------------------------
  // Fail timers
  // ----------------------------------------
  logic [NT-1:0] cond; // Quantity outside limits
  logic [NT-1:0][15:0] lim; // Qualifying time per timer
  logic [NT-1:0] expired; // Violation held long enough
  assign cond = {ocC, ovlC, revC, batC, frqC};
  assign lim = {ocDelay, ovlTime, revTime, batTime, frqTime};

  for (genvar g = 0; g < NT; g++) begin : g_tmr
    logic [15:0] cnt; // Ticks of uninterrupted violation
    // Count while violated, restart from zero on return
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cnt <= 16'h0000;
      end else if (!cond[g]) begin
        cnt <= 16'h0000;
      end else if (tick && (cnt != 16'hFFFF)) begin
        cnt <= cnt + 16'h0001;
      end
    end
    assign expired[g] = cond[g] && (cnt >= lim[g]);
  end

  // ----------------------------------------
  // Sticky fault causes
  // ----------------------------------------
  logic [12:0] set; // Fault causes this cycle
  logic [12:0] clr; // Software clear mask
  assign set = {
    expired[3],
    expired[4],
    expired[2] && revDumpC,
    expired[2] && revWarnC,
    iUnbC,
    vUnbC,
    expired[1] && batHighShutC,
    expired[1] && batHighWarnC,
    expired[1] && batLowShutC,
    expired[1] && batLowWarnC,
    expired[0] && frqHighShutC,
    expired[0] && frqHighWarnC,
    expired[0] && frqLowShutC
  };
  assign clr = (wrEn && (paddr == `GPM_STATUS)) ? pwdata[12:0] : 13'h0000;

  // Write one to clear; a new fault wins over the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= 13'h0000;
    end else begin
      status <= (status & ~clr) | set;
    end
  end

  // ----------------------------------------
  // Alarm classes and outputs
  // ----------------------------------------
  alarm_t vCls;
  alarm_t iCls;
  logic next_warn;
  logic next_dump;
  logic next_shut;
  assign vCls = actClass(vUnbAct, status[7]);
  assign iCls = actClass(iUnbAct, status[8]);
  assign next_warn = status[1] || status[3] || status[5] || status[9] ||
    vCls.warn || iCls.warn;
  assign next_dump = status[10] || status[12] || (status[11] && ocAct) ||
    vCls.dump || iCls.dump;
  assign next_shut = status[0] || status[2] || status[4] || status[6] ||
    (status[11] && !ocAct) || vCls.shut || iCls.shut;

  // Registered alarm drive; any shutdown stops the engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      warnOut <= 1'b0;
      dumpOut <= 1'b0;
      shutOut <= 1'b0;
      engineStop <= 1'b0;
    end else begin
      warnOut <= next_warn;
      dumpOut <= next_dump;
      shutOut <= next_shut;
      engineStop <= next_shut;
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    case (paddr)
      `GPM_CTRL: next_rdata = {23'h0, ocAct, iUnbAct, vUnbAct, 2'h0, nomSel};
      `GPM_NOMFREQ: next_rdata = {16'h0000, nomFreq};
      `GPM_FREQLIM: next_rdata = {8'h00, pctHighShut, pctHighWarn, pctLowShut};
      `GPM_BATLOW: next_rdata = {batLowShut, batLowWarn};
      `GPM_BATHIGH: next_rdata = {batHighShut, batHighWarn};
      `GPM_UNBAL: next_rdata = {16'h0000, iUnbLim, vUnbLim};
      `GPM_REVP: next_rdata = {revDumpLim, revWarnLim};
      `GPM_OCLIM1: next_rdata = {16'h0000, ocLim1};
      `GPM_OCLIM2: next_rdata = {16'h0000, ocLim2};
      `GPM_OCLIM3: next_rdata = {16'h0000, ocLim3};
      `GPM_OVL: next_rdata = {16'h0000, ovlLim};
      `GPM_TIMER1: next_rdata = {batTime, frqTime};
      `GPM_TIMER2: next_rdata = {ovlTime, revTime};
      `GPM_OCMULT: next_rdata = {25'h0, ocMult};
      `GPM_STATUS: next_rdata = {19'h0, status};
      // Live conditions and present alarm drive
      `GPM_LIVE: next_rdata = {21'h0, iUnbC, vUnbC, cond, engineStop, shutOut, dumpOut, warnOut};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Data and error captured in setup, held through access
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setupPh) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= !mapped;
      end
    end
  end

endmodule

// file: pkg/gpm_defs.svh
// Register offsets, reset values and timing counts of the protection monitor
//
// Functional notes
// - Low frequency below limit while feeding: shutdown
// - High frequency above warning limit: warning
// - High frequency above shutdown limit: shutdown
// - Frequency fault only after frequency fail timer
// - Battery low: warning, lower still: shutdown
// - Battery high: warning, higher still: shutdown
// - Battery fault only after battery fail timer
// - Phase voltage off average: unbalance; zero disables
// - Unbalance action code: none/shutdown/dump/warning
// - Phase current off average: unbalance; zero disables
// - Reverse power beyond warning limit: warning
// - Reverse power beyond dump limit: load dump
// - Reverse power fault only after its timer
// - Phase current above limit while feeding: overcurrent
// - Nominal select picks overcurrent limit one/two/three
// - Overcurrent action zero shutdown, one dump
// - Time multiplier sets overcurrent reaction speed
// - Active power above limit while feeding: dump
// - Overload fault only after overload timer
// - Frequency limits are percent of nominal frequency
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
// Byte offsets
`define GPM_CTRL 8'h00
`define GPM_NOMFREQ 8'h04
`define GPM_FREQLIM 8'h08
`define GPM_BATLOW 8'h0C
`define GPM_BATHIGH 8'h10
`define GPM_UNBAL 8'h14
`define GPM_REVP 8'h18
`define GPM_OCLIM1 8'h1C
`define GPM_OCLIM2 8'h20
`define GPM_OCLIM3 8'h24
`define GPM_OVL 8'h28
`define GPM_TIMER1 8'h2C
`define GPM_TIMER2 8'h30
`define GPM_OCMULT 8'h34
`define GPM_STATUS 8'h38
`define GPM_LIVE 8'h3C
// Reset values (frequency percent is signed, battery in 0.1 V, timers in 0.1 s ticks)
`define GPM_NOMFREQ_RST 16'h0032
`define GPM_LOWSHUT_RST 8'hEC
`define GPM_HIGHWARN_RST 8'h0F
`define GPM_HIGHSHUT_RST 8'h14
`define GPM_BLW_RST 16'h0078
`define GPM_BLS_RST 16'h005A
`define GPM_BHW_RST 16'h0122
`define GPM_BHS_RST 16'h012C
`define GPM_FRQT_RST 16'h000A
`define GPM_BATT_RST 16'h001E
`define GPM_REVT_RST 16'h0032
`define GPM_OVLT_RST 16'h001E
`define GPM_OCMULT_RST 7'h10
`define GPM_OCMULT_MAX 7'h40
`define GPM_OCDELAY_BASE 7'h41
// Timing: tick period in ms, clock period in ns
`define GPM_TICK_MS 100
`define GPM_CLK_NS 4
`define GPM_TICK_CYCLES (`GPM_TICK_MS * 1000000 / `GPM_CLK_NS)
`endif

// file: pkg/gpm_pkg.sv
// Types shared by the protection monitor
package gpm_pkg;
  // Unbalance response codes
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_SHUT = 2'h1,
    ACT_DUMP = 2'h2,
    ACT_WARN = 2'h3
  } action_t;
  // Alarm class triple
  typedef struct packed {
    logic shut;
    logic dump;
    logic warn;
  } alarm_t;
endpackage

// file: tb/gpm_chk.sv
// Port-level checker for the protection monitor
`timescale 1ns/1ps
module gpm_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic warnOut,
  input wire logic dumpOut,
  input wire logic shutOut,
  input wire logic engineStop
);
  // ----------------------------------------
  // Clocking and decode
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic accessPh; // Access phase of a transfer
  logic rdLive; // Read of the live state word
  assign accessPh = psel && penable;
  assign rdLive = accessPh && !pwrite && paddr == 8'h3C;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_stop_tracks_shut: assert property (engineStop == shutOut)
    else $error("engine stop differs from shutdown class");
  chk_ready_zero_wait: assert property (!$past(rst) |-> pready)
    else $error("slave not ready after reset");
  chk_err_bad_addr: assert property (accessPh && (paddr[1:0] != 2'h0 || paddr > 8'h3C) |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_good_addr: assert property (accessPh && paddr[1:0] == 2'h0 && paddr <= 8'h3C |-> !pslverr)
    else $error("mapped access refused");
  chk_err_read_zero: assert property (accessPh && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_live_echo: assert property (rdLive |-> prdata[3:0] == $past({engineStop, shutOut, dumpOut, warnOut}))
    else $error("live word does not echo outputs");
  chk_live_reserved: assert property (rdLive |-> prdata[31:11] == 21'h0)
    else $error("live word reserved bits set");
  chk_mult_range: assert property (accessPh && !pwrite && paddr == 8'h34 |-> prdata inside {[1:64]})
    else $error("time multiplier out of range");
  chk_status_reserved: assert property (accessPh && !pwrite && paddr == 8'h38 |-> prdata[31:13] == 19'h0)
    else $error("status reserved bits set");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cov_stop: cover property ($rose(engineStop));
  cov_dump: cover property ($rose(dumpOut));
  cov_warn: cover property ($rose(warnOut));
  cov_refuse: cover property (accessPh && pslverr);
endmodule
bind genset_protection_monitor gpm_chk chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .warnOut(warnOut), .dumpOut(dumpOut), .shutOut(shutOut),
  .engineStop(engineStop));

// file: tb/gen_front_end.sv
// Measurement front end model feeding the protection monitor
`timescale 1ns/1ps
module gen_front_end (
  input wire logic ref_clk,
  input wire logic setFeed,
  input wire logic [15:0] setFreq,
  input wire logic [15:0] setBatt,
  input wire logic [2:0][15:0] setV,
  input wire logic [2:0][15:0] setI,
  input wire logic signed [31:0] setP,
  output logic feedingLoad,
  output logic [15:0] genFreq,
  output logic [15:0] battV,
  output logic [2:0][15:0] phaseV,
  output logic [2:0][15:0] phaseI,
  output logic signed [31:0] actPower
);
  // ----------------------------------------
  // Sampled measurements, one cycle of conversion latency
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    feedingLoad <= setFeed;
    genFreq <= setFreq;
    battV <= setBatt;
    phaseV <= setV;
    phaseI <= setI;
    actPower <= setP;
  end
endmodule

// file: tb/test_genset_protection_monitor.sv
// Self-checking bench for the protection monitor
`timescale 1ns/1ps
module test_genset_protection_monitor;
  // ----------------------------------------
  // Signals and bench state
  // ----------------------------------------
  localparam int OC1 = 100, OC2 = 200, OC3 = 300, RW = 100, RD = 500, OV = 1000;
  localparam logic [7:0] RA [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h2C, 8'h30, 8'h34};
  localparam logic [31:0] RV [7] = '{32'h32, 32'h00140FEC, 32'h005A0078, 32'h012C0122,
    32'h001E000A, 32'h001E0032, 32'h10};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, warnOut, dumpOut, shutOut, engineStop, er, feedingLoad;
  logic [15:0] genFreq, battV;
  logic [2:0][15:0] phaseV, phaseI;
  logic signed [31:0] actPower;
  logic sFeed = 1'b0; // Commanded measurements
  logic [15:0] sFreq = 16'h01F4, sBatt = 16'h00F0;
  logic [2:0][15:0] sV = {3{16'h00E6}}, sI = {3{16'h0032}};
  logic signed [31:0] sP = 32'sh0;
  logic [1:0] sel = 2'h0, va = 2'h0, ca = 2'h0; // Mirror of control word
  logic oca = 1'b0;
  logic [31:0] seed = 32'h00011AF3;
  int nom = 50, badCount = 0, checked = 0, cycles = 0;
  always #2 ref_clk = ~ref_clk;
  gen_front_end fe (.ref_clk(ref_clk), .setFeed(sFeed), .setFreq(sFreq), .setBatt(sBatt),
    .setV(sV), .setI(sI), .setP(sP), .feedingLoad(feedingLoad), .genFreq(genFreq),
    .battV(battV), .phaseV(phaseV), .phaseI(phaseI), .actPower(actPower));
  genset_protection_monitor #(.TICK_CYCLES(4)) uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .feedingLoad(feedingLoad), .genFreq(genFreq),
    .battV(battV), .phaseV(phaseV), .phaseI(phaseI), .actPower(actPower), .warnOut(warnOut),
    .dumpOut(dumpOut), .shutOut(shutOut), .engineStop(engineStop));
  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic logic [31:0] pick(input int unsigned span);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed % span;
  endfunction
  function automatic logic off(input logic [2:0][15:0] x, input int lim);
    int s, t;
    s = x[0] + x[1] + x[2];
    off = 1'b0;
    for (int k = 0; k < 3; k++) begin
      t = 3 * int'(x[k]) - s;
      if ((t < 0 ? -t : t) * 100 > lim * s) off = 1'b1;
    end
  endfunction
  function automatic logic [12:0] expStat(input logic on);
    int f, lim;
    logic [12:0] e;
    f = sFreq * 100;
    e = 13'h0;
    e[0] = sFeed && f < nom * 800;
    e[1] = sFeed && f > nom * 1150;
    e[2] = sFeed && f > nom * 1200;
    e[3] = sBatt < 120;
    e[4] = sBatt < 90;
    e[5] = sBatt > 290;
    e[6] = sBatt > 300;
    lim = sel == 2'h1 ? OC2 : (sel == 2'h2 ? OC3 : OC1);
    if (on) begin
      e[7] = off(sV, 10);
      e[8] = off(sI, 10);
      e[9] = sP < 0 && -sP > RW;
      e[10] = sP < 0 && -sP > RD;
      e[11] = sFeed && (sI[0] > lim || sI[1] > lim || sI[2] > lim);
      e[12] = sFeed && sP > OV;
    end
    return e;
  endfunction
  function automatic logic [2:0] cls(input logic [12:0] e);
    logic w, d, s;
    w = e[1] | e[3] | e[5] | e[9] | (e[7] && va == 3) | (e[8] && ca == 3);
    d = e[10] | e[12] | (e[11] && oca) | (e[7] && va == 2) | (e[8] && ca == 2);
    s = e[0] | e[2] | e[4] | e[6] | (e[11] && !oca) | (e[7] && va == 1) | (e[8] && ca == 1);
    return {s, d, w};
  endfunction
  // ----------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic runCase(input logic on);
    logic [12:0] e;
    logic [2:0] c;
    repeat (4) @(posedge ref_clk);
    e = expStat(on);
    apb(1'b1, 8'h38, 32'h1FFF);
    repeat (300) @(posedge ref_clk);
    apb(1'b0, 8'h38, 32'h0);
    check(r, {19'h0, e});
    c = cls(e);
    check({28'h0, engineStop, shutOut, dumpOut, warnOut}, {28'h0, c[2], c});
    // Live word: raw limit crossings per group and the present alarm drive
    apb(1'b0, 8'h3C, 32'h0);
    check(r, {21'h0, e[8], e[7], e[11], e[12], e[10] | e[9], |e[6:3], |e[2:0], c[2], c});
  endtask
  task automatic randMeas();
    sFeed <= pick(4) != 0;
    sFreq <= 16'(nom * 7 + pick(nom * 7));
    sBatt <= 16'(50 + pick(300));
    for (int k = 0; k < 3; k++) sV[k] <= 16'(200 + pick(60));
    for (int k = 0; k < 3; k++) sI[k] <= 16'(50 + pick(300));
    sP <= $signed(pick(2400)) - 800;
  endtask
  task automatic conclude();
    $display("counts: checked %0d bad %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 15000) begin
      badCount++;
      conclude();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, RA[k], 32'h0);
      check(r, RV[k]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, 8'h06, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, 8'h34, 32'h0);
    apb(1'b0, 8'h34, 32'h0);
    check(r, 32'h1);
    apb(1'b1, 8'h34, 32'h64);
    apb(1'b0, 8'h34, 32'h0);
    check(r, 32'h40);
    apb(1'b1, 8'h34, 32'h10);
    $display("test registers done");
    sFeed <= 1'b1;
    apb(1'b1, 8'h38, 32'h1FFF);
    sFreq <= 16'h015E;
    repeat (28) @(posedge ref_clk);
    apb(1'b0, 8'h38, 32'h0);
    check(r, 32'h0);
    sFreq <= 16'h01F4;
    repeat (2) @(posedge ref_clk);
    sFreq <= 16'h015E;
    repeat (28) @(posedge ref_clk);
    apb(1'b0, 8'h38, 32'h0);
    check(r, 32'h0);
    repeat (24) @(posedge ref_clk);
    apb(1'b0, 8'h38, 32'h0);
    check(r, 32'h1);
    // Low battery must wait for its own, longer timer
    sBatt <= 16'h0064;
    apb(1'b1, 8'h38, 32'h1FFF);
    repeat (80) @(posedge ref_clk);
    apb(1'b0, 8'h38, 32'h0);
    check(r, 32'h1);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, 8'h38, 32'h0);
    check(r, 32'h9);
    $display("test fail timer done");
    randMeas();
    runCase(1'b0);
    apb(1'b1, 8'h14, 32'h0A0A);
    apb(1'b1, 8'h18, 32'h01F40064);
    apb(1'b1, 8'h1C, 32'h64);
    apb(1'b1, 8'h20, 32'hC8);
    apb(1'b1, 8'h24, 32'h12C);
    apb(1'b1, 8'h28, 32'h3E8);
    sFeed <= 1'b0;
    sFreq <= 16'h01F4;
    sBatt <= 16'h00F0;
    sV <= {16'h00C8, 16'h0104, 16'h0104};
    sI <= {3{16'h0032}};
    sP <= 32'sh0;
    for (int a = 0; a < 4; a++) begin
      va = a[1:0];
      apb(1'b1, 8'h00, {26'h0, va, 4'h0});
      runCase(1'b1);
    end
    $display("test action codes done");
    for (int i = 0; i < 24; i++) begin
      sel = 2'(pick(4));
      va = 2'(pick(4));
      ca = 2'(pick(4));
      oca = 1'(pick(2));
      apb(1'b1, 8'h00, {23'h0, oca, ca, va, 2'h0, sel});
      if (i == 12) begin
        nom = 60;
        apb(1'b1, 8'h04, 32'h3C);
      end
      randMeas();
      runCase(1'b1);
    end
    $display("test random limits done");
    conclude();
  end
endmodule
